/* File: shared/usbps_defs.vh */
// Constants for the USB/PS2 status and control block.
// Included by the status and control module only; holds definitions only.
`ifndef USBPS_DEFS_VH
`define USBPS_DEFS_VH

// Register indices; byte address is four times the index
`define USBPS_IDX_STATUS_CONTROL 8'h1A
`define USBPS_IDX_ENDPOINT_EVENT 8'h1B
`define USBPS_IDX_CLOCK_CONTROL  8'h1C

// Status and control register fields
`define USBPS_SC_SUSPEND     0
`define USBPS_SC_REMOTE_WAKE 1
`define USBPS_SC_BUS_RESET   2
`define USBPS_SC_RESUME      3
`define USBPS_SC_DATA_IN     4
`define USBPS_SC_CLOCK_IN    5
`define USBPS_SC_DATA_OUT    6
`define USBPS_SC_CLOCK_OUT   7

// Endpoint event and select register fields
`define USBPS_EP_FLAG_LSB    0
`define USBPS_EP_COUNT       4
`define USBPS_EP_PS2_SEL     4
`define USBPS_EP_USB_SEL     5
`define USBPS_EP_ADC_REF     6
`define USBPS_EP_FIFO_DIR    7

// Clock control register fields
`define USBPS_CC_USB_CLK_EN  3
`define USBPS_CC_DEEP_BUS_SUSPEND_FLAG   4

// Reset values
`define USBPS_RST_DRIVE      1'b1
`define USBPS_RST_PS2_SEL    1'b0
`define USBPS_RST_USB_SEL    1'b0
`define USBPS_RST_ADC_REF    1'b1
`define USBPS_RST_FIFO_DIR   1'b0
`define USBPS_RST_CLOCK_CTRL 8'h00

// Timing
`define USBPS_CLOCK_PERIOD_NS 40
`define USBPS_WAKE_HOLD_NS    2000
`define USBPS_RESUME_HOLD_MS  20
`define USBPS_WAKE_HOLD_CYCLES \
  ((`USBPS_WAKE_HOLD_NS + `USBPS_CLOCK_PERIOD_NS - 1) / `USBPS_CLOCK_PERIOD_NS)
`define USBPS_RESUME_HOLD_CYCLES \
  ((`USBPS_RESUME_HOLD_MS * 1000000) / `USBPS_CLOCK_PERIOD_NS)

`endif

/* File: src/usbps_pin_sync.v */
// Two-stage synchroniser for a group of pin levels.
// Assumes asynchronous inputs; only the second stage is read outside.
`timescale 1ns/1ps
`default_nettype none

module usbps_pin_sync #(
  parameter WIDTH = 2
) (
  input  wire             i_clock,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg meta_ff;
      reg sync_ff;
      always @(posedge i_clock) begin
        if (i_rst) begin
          meta_ff <= 1'b1;
          sync_ff <= 1'b1;
        end else begin
          meta_ff <= i_async[gi];
          sync_ff <= meta_ff;
        end
      end
      assign o_sync[gi] = sync_ff;
    end
  endgenerate

endmodule

`default_nettype wire

/* File: src/usbps_hold_timer.v */
// Hold timer: reports once its run input has been high for LIMIT cycles.
// Assumes a synchronous run level; dropping run restarts the count.
`timescale 1ns/1ps
`default_nettype none

module usbps_hold_timer #(
  parameter WIDTH = 20,
  parameter LIMIT = 50
) (
  input  wire i_clock,
  input  wire i_rst,
  input  wire i_run,
  output wire o_done
);

  localparam integer     LAST_INT = LIMIT - 1;
  localparam [WIDTH-1:0] LAST     = LAST_INT[WIDTH-1:0];

  reg [WIDTH-1:0] count_ff;
  reg             done_ff;

  always @(posedge i_clock) begin
    if (i_rst || !i_run) begin
      count_ff <= {WIDTH{1'b0}};
      done_ff  <= 1'b0;
    end else if (!done_ff) begin
      count_ff <= count_ff + 1'b1;
      done_ff  <= (count_ff == LAST);
    end
  end

  assign o_done = done_ff;

endmodule

`default_nettype wire

/* File: src/usbps_status_control.v */
// USB/PS2 status and control registers with an Avalon-MM slave port.
// Assumes serial engine strobes on i_clock; cable pins are asynchronous.
//
// Contract
// - Suspend flag mirrors bus suspend state
// - Suspend flag change raises USB interrupt
// - Remote wake bit commands host wakeup
// - Bus reset sets flag, interrupts, engine clears
// - Resume flag set, visible twenty milliseconds
// - Resume flag set wakes halted core
// - Resume clears when suspend flag falls, or at window end if it fell sooner; a fall in the set cycle is lost
// - Bits four, five read pin levels
// - Bits six, seven drive pins, reset one
// - Endpoint access sets flag, requests interrupt
// - Interrupt taken only enabled, stack free
// - Bit four selects PS2 function
// - Bit five selects USB function
// - Bit six selects internal A/D reference
// - Bit seven emulator FIFO direction, write-only
// - USB clock runs only when enabled
`timescale 1ns/1ps
`default_nettype none
`include "usbps_defs.vh"

module usbps_status_control #(
  parameter RESUME_CYCLES = `USBPS_RESUME_HOLD_CYCLES,
  parameter RESUME_WIDTH  = 20
) (
  input  wire        i_clock,
  input  wire        i_rst,
  // Avalon-MM slave, word addressed
  input  wire [7:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output wire [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // Serial interface engine
  input  wire        i_sie_suspend,
  input  wire        i_sie_bus_reset,
  input  wire        i_sie_bus_reset_clear,
  input  wire        i_sie_resume,
  input  wire [3:0]  i_sie_ep_access,
  output wire        o_sie_remote_wake,
  output wire        o_sie_clock_enable,
  output wire        o_sie_deep_suspend,
  // Processor core
  input  wire        i_usb_int_enable,
  input  wire        i_stack_full,
  output wire        o_usb_event,
  output wire        o_usb_int_take,
  output wire        o_core_wake,
  // Cable pins, D-/data and D+/clock
  input  wire        i_pin_data,
  input  wire        i_pin_clock,
  output wire        o_pin_data,
  output wire        o_pin_data_oe,
  output wire        o_pin_clock,
  output wire        o_pin_clock_oe,
  // Mode outputs
  output wire        o_ps2_function_select,
  output wire        o_usb_function_select,
  output wire        o_adc_internal_reference_select,
  output wire        o_fifo_write_direction
);

  localparam WAKE_CYCLES = `USBPS_WAKE_HOLD_CYCLES;

  // Bus access state
  reg         ack_ff;
  reg  [31:0] readdata_ff;
  reg  [31:0] nxt_readdata;

  // Status and control register
  reg         bus_suspend_flag_ff;
  reg         remote_wake_request_ff;
  reg         bus_reset_flag_ff;
  reg         resume_flag_ff;
  reg         ps2_data_out_drive_ff;
  reg         ps2_clock_out_drive_ff;
  reg         wake_sent_ff;
  reg         resume_pending_clear_ff;

  // Endpoint event and select register
  reg  [3:0]  endpoint_access_flag_ff;
  reg         ps2_function_select_ff;
  reg         usb_function_select_ff;
  reg         adc_internal_reference_select_ff;
  reg         fifo_direction_ff;

  // Clock control register
  reg  [7:0]  clock_control_ff;

  reg         usb_event_ff;
  reg         core_wake_ff;

  wire [1:0]  pin_level;
  wire        ps2_data_in_level;
  wire        ps2_clock_in_level;
  wire        wake_held;
  wire        resume_held;

  wire        bus_req;
  wire        wr_take;
  wire        wr_lane0;
  wire [7:0]  wdata;
  wire        wr_status;
  wire        wr_endpoint;
  wire        wr_clock;
  wire        suspend_fall;
  wire        suspend_change;
  wire        resume_set;
  wire [3:0]  ep_clear;

  // Pin levels pass two flip-flops before anything reads them
  usbps_pin_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async ({i_pin_clock, i_pin_data}),
    .o_sync  (pin_level)
  );

  assign ps2_data_in_level  = pin_level[0];
  assign ps2_clock_in_level = pin_level[1];

  // Wake command is passed on only after the bit has stood long enough
  usbps_hold_timer #(
    .WIDTH (8),
    .LIMIT (WAKE_CYCLES)
  ) u_wake_timer (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_run   (remote_wake_request_ff),
    .o_done  (wake_held)
  );

  usbps_hold_timer #(
    .WIDTH (RESUME_WIDTH),
    .LIMIT (RESUME_CYCLES)
  ) u_resume_timer (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_run   (resume_flag_ff),
    .o_done  (resume_held)
  );

  // Avalon slave: one wait cycle, then the access completes
  assign bus_req           = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = bus_req & ~ack_ff;
  assign o_avs_readdata    = readdata_ff;

  always @(posedge i_clock) begin
    if (i_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  assign wr_take     = i_avs_write & ack_ff;
  assign wr_lane0    = wr_take & i_avs_byteenable[0];
  assign wdata       = i_avs_writedata[7:0];
  assign wr_status   = wr_lane0 && (i_avs_address == `USBPS_IDX_STATUS_CONTROL);
  assign wr_endpoint = wr_lane0 && (i_avs_address == `USBPS_IDX_ENDPOINT_EVENT);
  assign wr_clock    = wr_lane0 && (i_avs_address == `USBPS_IDX_CLOCK_CONTROL);

  // Read data; write-only bits and unmapped words read as zero
  always @* begin
    nxt_readdata = 32'h00000000;
    case (i_avs_address)
      `USBPS_IDX_STATUS_CONTROL: begin
        nxt_readdata[`USBPS_SC_SUSPEND]   = bus_suspend_flag_ff;
        nxt_readdata[`USBPS_SC_BUS_RESET] = bus_reset_flag_ff;
        nxt_readdata[`USBPS_SC_RESUME]    = resume_flag_ff;
        nxt_readdata[`USBPS_SC_DATA_IN]   = ps2_data_in_level;
        nxt_readdata[`USBPS_SC_CLOCK_IN]  = ps2_clock_in_level;
      end
      `USBPS_IDX_ENDPOINT_EVENT: begin
        nxt_readdata[3:0]                 = endpoint_access_flag_ff;
        nxt_readdata[`USBPS_EP_PS2_SEL]   = ps2_function_select_ff;
        nxt_readdata[`USBPS_EP_USB_SEL]   = usb_function_select_ff;
        nxt_readdata[`USBPS_EP_ADC_REF]   = adc_internal_reference_select_ff;
      end
      `USBPS_IDX_CLOCK_CONTROL: begin
        nxt_readdata[7:0]                 = clock_control_ff;
      end
      default: begin
        nxt_readdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      readdata_ff <= 32'h00000000;
    end else if (i_avs_read && !ack_ff) begin
      readdata_ff <= nxt_readdata;
    end
  end

  // Suspend indication follows the engine; its level gates resume, its edges raise events
  always @(posedge i_clock) begin
    if (i_rst) begin
      bus_suspend_flag_ff <= 1'b0;
    end else begin
      bus_suspend_flag_ff <= i_sie_suspend;
    end
  end

  assign suspend_fall   = bus_suspend_flag_ff & ~i_sie_suspend;
  assign suspend_change = bus_suspend_flag_ff ^ i_sie_suspend;

  // Remote wake request; passed on only once firmware has held it long enough
  always @(posedge i_clock) begin
    if (i_rst) begin
      remote_wake_request_ff <= 1'b0;
      wake_sent_ff           <= 1'b0;
    end else begin
      if (wr_status) begin
        remote_wake_request_ff <= wdata[`USBPS_SC_REMOTE_WAKE];
      end
      if (!remote_wake_request_ff) begin
        wake_sent_ff <= 1'b0;
      end else if (wake_held) begin
        wake_sent_ff <= 1'b1;
      end
    end
  end

  // One pulse per accepted request, once it has stood the hold time
  assign o_sie_remote_wake = wake_held & ~wake_sent_ff;

  // Bus reset flag: engine sets, engine or a zero firmware write clears; a set beats any clear
  always @(posedge i_clock) begin
    if (i_rst) begin
      bus_reset_flag_ff <= 1'b0;
    end else if (i_sie_bus_reset) begin
      bus_reset_flag_ff <= 1'b1;
    end else if (i_sie_bus_reset_clear) begin
      bus_reset_flag_ff <= 1'b0;
    end else if (wr_status && !wdata[`USBPS_SC_BUS_RESET]) begin
      bus_reset_flag_ff <= 1'b0;
    end
  end

  // Resume indication. A suspend fall before the hold time has run
  // only arms the clear, so firmware always sees the full window.
  assign resume_set = i_sie_resume & bus_suspend_flag_ff;

  always @(posedge i_clock) begin
    if (i_rst) begin
      resume_flag_ff          <= 1'b0;
      resume_pending_clear_ff <= 1'b0;
    end else if (resume_set) begin
      resume_flag_ff          <= 1'b1;
      resume_pending_clear_ff <= 1'b0;
    end else if (resume_flag_ff) begin
      if (suspend_fall && resume_held) begin
        resume_flag_ff <= 1'b0;
      end else if (suspend_fall) begin
        resume_pending_clear_ff <= 1'b1;
      end else if (resume_pending_clear_ff && resume_held) begin
        resume_flag_ff          <= 1'b0;
        resume_pending_clear_ff <= 1'b0;
      end
    end
  end

  // Wake the halted core on the rise of the resume indication
  always @(posedge i_clock) begin
    if (i_rst) begin
      core_wake_ff <= 1'b0;
    end else begin
      core_wake_ff <= resume_set & ~resume_flag_ff;
    end
  end

  assign o_core_wake = core_wake_ff;

  // Bus event pulse: suspend edges and bus reset detection
  always @(posedge i_clock) begin
    if (i_rst) begin
      usb_event_ff <= 1'b0;
    end else begin
      usb_event_ff <= suspend_change | i_sie_bus_reset;
    end
  end

  assign o_usb_event = usb_event_ff;

  // PS2 drive bits; the pins are driven only in PS2 mode
  always @(posedge i_clock) begin
    if (i_rst) begin
      ps2_data_out_drive_ff  <= `USBPS_RST_DRIVE;
      ps2_clock_out_drive_ff <= `USBPS_RST_DRIVE;
    end else if (wr_status) begin
      ps2_data_out_drive_ff  <= wdata[`USBPS_SC_DATA_OUT];
      ps2_clock_out_drive_ff <= wdata[`USBPS_SC_CLOCK_OUT];
    end
  end

  assign o_pin_data     = ps2_data_out_drive_ff;
  assign o_pin_clock    = ps2_clock_out_drive_ff;
  assign o_pin_data_oe  = ps2_function_select_ff;
  assign o_pin_clock_oe = ps2_function_select_ff;

  // Endpoint access flags: engine sets, only firmware clears, set wins
  assign ep_clear = wr_endpoint ? ~wdata[3:0] : 4'h0;

  genvar gi;
  generate
    for (gi = 0; gi < `USBPS_EP_COUNT; gi = gi + 1) begin : g_ep
      always @(posedge i_clock) begin
        if (i_rst) begin
          endpoint_access_flag_ff[gi] <= 1'b0;
        end else if (i_sie_ep_access[gi]) begin
          endpoint_access_flag_ff[gi] <= 1'b1;
        end else if (ep_clear[gi]) begin
          endpoint_access_flag_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt take is a level while any flag stands, enabled and stack not full
  assign o_usb_int_take = (|endpoint_access_flag_ff) & i_usb_int_enable
                          & ~i_stack_full;

  // Mode selects
  always @(posedge i_clock) begin
    if (i_rst) begin
      ps2_function_select_ff           <= `USBPS_RST_PS2_SEL;
      usb_function_select_ff           <= `USBPS_RST_USB_SEL;
      adc_internal_reference_select_ff <= `USBPS_RST_ADC_REF;
      fifo_direction_ff                <= `USBPS_RST_FIFO_DIR;
    end else if (wr_endpoint) begin
      ps2_function_select_ff           <= wdata[`USBPS_EP_PS2_SEL];
      usb_function_select_ff           <= wdata[`USBPS_EP_USB_SEL];
      adc_internal_reference_select_ff <= wdata[`USBPS_EP_ADC_REF];
      fifo_direction_ff                <= wdata[`USBPS_EP_FIFO_DIR];
    end
  end

  assign o_ps2_function_select           = ps2_function_select_ff;
  assign o_usb_function_select           = usb_function_select_ff;
  assign o_adc_internal_reference_select = adc_internal_reference_select_ff;
  assign o_fifo_write_direction          = fifo_direction_ff;

  // Clock control; suspend detection needs the clock on and deep save off
  always @(posedge i_clock) begin
    if (i_rst) begin
      clock_control_ff <= `USBPS_RST_CLOCK_CTRL;
    end else if (wr_clock) begin
      clock_control_ff <= wdata;
    end
  end

  assign o_sie_clock_enable = clock_control_ff[`USBPS_CC_USB_CLK_EN];
  assign o_sie_deep_suspend = clock_control_ff[`USBPS_CC_DEEP_BUS_SUSPEND_FLAG];

endmodule

`default_nettype wire

/* File: testbench/usbps_status_control_sva.sv */
// Port-level checker for the USB/PS2 status and control block.
// Sees only top-level ports; bound onto every instance below.
`timescale 1ns/1ps
`default_nettype none

module usbps_status_control_sva (
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire logic       i_avs_read,
  input wire logic       i_avs_write,
  input wire logic       o_avs_waitrequest,
  input wire logic       i_sie_suspend,
  input wire logic       i_sie_bus_reset,
  input wire logic       i_sie_resume,
  input wire logic [3:0] i_sie_ep_access,
  input wire logic       o_sie_remote_wake,
  input wire logic       i_usb_int_enable,
  input wire logic       i_stack_full,
  input wire logic       o_usb_event,
  input wire logic       o_usb_int_take,
  input wire logic       o_core_wake,
  input wire logic       o_pin_data_oe,
  input wire logic       o_ps2_function_select,
  input wire logic       o_usb_function_select
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence s_req_rise;
    $rose(i_avs_read || i_avs_write);
  endsequence
  sequence s_one_wait;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence
  sequence s_ep_then_open;
    (|i_sie_ep_access) ##1 (i_usb_int_enable && !i_stack_full);
  endsequence

  bus_one_wait_a: assert property (s_req_rise |-> s_one_wait)
    else $error("bus request did not complete after one wait cycle");
  suspend_event_a: assert property ($changed(i_sie_suspend) |-> ##[1:2] o_usb_event)
    else $error("suspend change raised no event");
  reset_event_a: assert property (i_sie_bus_reset |-> ##[1:2] o_usb_event)
    else $error("bus reset raised no event");
  take_gated_a: assert property (o_usb_int_take |-> i_usb_int_enable && !i_stack_full)
    else $error("interrupt taken while disabled or stack full");
  ep_take_a: assert property (s_ep_then_open |-> o_usb_int_take)
    else $error("endpoint access did not request the interrupt");
  core_wake_a: assert property (o_core_wake |-> $past(i_sie_resume) ##1 !o_core_wake)
    else $error("core wake without resume or longer than one cycle");
  wake_pulse_a: assert property (o_sie_remote_wake |=> !o_sie_remote_wake)
    else $error("remote wake pulse longer than one cycle");
  pin_enable_a: assert property (o_pin_data_oe == o_ps2_function_select)
    else $error("data pin enable differs from function select");
  usb_sel_a: assert property ($changed(o_usb_function_select) |-> $past(i_avs_write && !o_avs_waitrequest))
    else $error("function select changed without a write");
endmodule

bind usbps_status_control usbps_status_control_sva u_usbps_status_control_sva (
  .i_clock(i_clock), .i_rst(i_rst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .i_sie_suspend(i_sie_suspend), .i_sie_bus_reset(i_sie_bus_reset),
  .i_sie_resume(i_sie_resume), .i_sie_ep_access(i_sie_ep_access), .o_sie_remote_wake(o_sie_remote_wake),
  .i_usb_int_enable(i_usb_int_enable), .i_stack_full(i_stack_full), .o_usb_event(o_usb_event),
  .o_usb_int_take(o_usb_int_take), .o_core_wake(o_core_wake), .o_pin_data_oe(o_pin_data_oe),
  .o_ps2_function_select(o_ps2_function_select), .o_usb_function_select(o_usb_function_select)
);
`default_nettype wire

/* File: testbench/usbps_host_model.sv */
// Cable-side host model: two pulled-up lines the host may pull low.
// Assumes the device drives a line only while its enable is high.
`timescale 1ns/1ps
`default_nettype none

module usbps_host_model (
  input  wire logic i_dev_data,
  input  wire logic i_dev_data_oe,
  input  wire logic i_dev_clock,
  input  wire logic i_dev_clock_oe,
  input  wire logic i_host_data_low,
  input  wire logic i_host_clock_low,
  output wire logic o_line_data,
  output wire logic o_line_clock
);
  // Wired-and: any party pulling low wins, released lines float up
  assign o_line_data  = !i_host_data_low && !(i_dev_data_oe && !i_dev_data);
  assign o_line_clock = !i_host_clock_low && !(i_dev_clock_oe && !i_dev_clock);
endmodule
`default_nettype wire

/* File: testbench/test_usb_ps2_status_control.sv */
// Self-checking bench for the USB/PS2 status and control block.
// Assumes a short resume hold parameter; bus waits are not counted.
`timescale 1ns/1ps
`default_nettype none

module test_usb_ps2_status_control;
  localparam int         RESUME = 20;
  localparam logic [7:0] A_SC   = 8'h1A;
  localparam logic [7:0] A_EP   = 8'h1B;
  localparam logic [7:0] A_CC   = 8'h1C;
  logic        i_clock = 1'b0;
  logic        i_rst   = 1'b1;
  logic [7:0]  adr     = 8'h00;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic        bus_suspend_flag    = 1'b0;
  logic        breset  = 1'b0;
  logic        bclear  = 1'b0;
  logic        resume  = 1'b0;
  logic [3:0]  ep      = 4'h0;
  logic        int_en  = 1'b0;
  logic        full    = 1'b0;
  logic        h_data  = 1'b0;
  logic        h_clock = 1'b0;
  wire  [31:0] rdata;
  wire         waitreq, rwake, clk_en, deep, event_p, take, cwake, line_d, line_c;
  wire         pd, pd_oe, pc, pc_oe, ps2_sel, usb_sel, adc_ref, fifo_dir;
  int          err_total = 0;
  int          n_tests   = 0;
  int          cycles    = 0;
  int          ev_cnt    = 0;
  int          wk_cnt    = 0;
  int          cw_cnt    = 0;

  usbps_status_control #(.RESUME_CYCLES(RESUME), .RESUME_WIDTH(20)) u_usbps_status_control (
    .i_clock(i_clock), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_sie_suspend(bus_suspend_flag), .i_sie_bus_reset(breset), .i_sie_bus_reset_clear(bclear), .i_sie_resume(resume),
    .i_sie_ep_access(ep), .o_sie_remote_wake(rwake), .o_sie_clock_enable(clk_en), .o_sie_deep_suspend(deep),
    .i_usb_int_enable(int_en), .i_stack_full(full), .o_usb_event(event_p), .o_usb_int_take(take),
    .o_core_wake(cwake), .i_pin_data(line_d), .i_pin_clock(line_c), .o_pin_data(pd), .o_pin_data_oe(pd_oe),
    .o_pin_clock(pc), .o_pin_clock_oe(pc_oe), .o_ps2_function_select(ps2_sel),
    .o_usb_function_select(usb_sel), .o_adc_internal_reference_select(adc_ref), .o_fifo_write_direction(fifo_dir));

  usbps_host_model u_usbps_host_model (
    .i_dev_data(pd), .i_dev_data_oe(pd_oe), .i_dev_clock(pc), .i_dev_clock_oe(pc_oe),
    .i_host_data_low(h_data), .i_host_clock_low(h_clock), .o_line_data(line_d), .o_line_clock(line_c));

  initial begin
    forever #20 i_clock = ~i_clock;
  end

  // Pulses counted mid-cycle so no edge race decides the count
  always @(negedge i_clock) begin
    if (event_p === 1'b1) ev_cnt++;
    if (rwake === 1'b1) wk_cnt++;
    if (cwake === 1'b1) cw_cnt++;
  end

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude;
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // Request held until waitrequest is seen low at a rising edge; data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    adr   <= a;
    wdata <= {24'h0, d};
    wr    <= w;
    rd    <= !w;
    @(posedge i_clock);
    while (waitreq !== 1'b0) @(posedge i_clock);
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check(32'(q), 32'(e));
  endtask

  task automatic t_reset;
    rdchk(A_SC, 8'h30);
    rdchk(A_EP, 8'h40);
    rdchk(A_CC, 8'h00);
    check(32'({pd, pc, pd_oe, pc_oe, adc_ref, fifo_dir, clk_en, deep, ps2_sel, usb_sel}), 32'(10'h320));
  endtask

  task automatic t_regs;
    wr8(8'h1D, 8'hFF);
    rdchk(8'h1D, 8'h00);
    wr8(A_CC, 8'hF7);
    check(32'({clk_en, deep}), 32'(2'b01));
    rdchk(A_CC, 8'hF7);
    wr8(A_CC, 8'h08);
    check(32'({clk_en, deep}), 32'(2'b10));
    wr8(A_EP, 8'hA0);
    check(32'({ps2_sel, usb_sel, adc_ref, fifo_dir}), 32'(4'h5));
    rdchk(A_EP, 8'h20);
    wr8(A_EP, 8'h40);
  endtask

  task automatic t_pins;
    h_data <= 1'b1;
    cyc(4);
    rdchk(A_SC, 8'h20);
    h_data  <= 1'b0;
    h_clock <= 1'b1;
    cyc(4);
    rdchk(A_SC, 8'h10);
    h_clock <= 1'b0;
    wr8(A_EP, 8'h50);
    wr8(A_SC, 8'h89);
    check(32'({pd, pc, pd_oe, pc_oe}), 32'(4'h7));
    cyc(4);
    rdchk(A_SC, 8'h20);
    wr8(A_SC, 8'hC0);
    wr8(A_EP, 8'h40);
  endtask

  task automatic t_suspend;
    int e0;
    int c0;
    e0 = ev_cnt;
    c0 = cw_cnt;
    bus_suspend_flag <= 1'b1;
    cyc(4);
    check(ev_cnt - e0, 1);
    rdchk(A_SC, 8'h31);
    resume <= 1'b1;
    cyc(1);
    resume <= 1'b0;
    cyc(3);
    check(cw_cnt - c0, 1);
    bus_suspend_flag <= 1'b0;
    cyc(4);
    check(ev_cnt - e0, 2);
    rdchk(A_SC, 8'h38);
    cyc(RESUME + 10);
    rdchk(A_SC, 8'h30);
    bus_suspend_flag <= 1'b1;
    cyc(3);
    resume <= 1'b1;
    cyc(1);
    resume <= 1'b0;
    cyc(RESUME + 10);
    rdchk(A_SC, 8'h39);
    bus_suspend_flag <= 1'b0;
    cyc(3);
    rdchk(A_SC, 8'h30);
  endtask

  task automatic t_bus_reset;
    int e0;
    e0 = ev_cnt;
    breset <= 1'b1;
    cyc(1);
    breset <= 1'b0;
    cyc(3);
    check(ev_cnt - e0, 1);
    rdchk(A_SC, 8'h34);
    bclear <= 1'b1;
    cyc(1);
    bclear <= 1'b0;
    cyc(1);
    rdchk(A_SC, 8'h30);
  endtask

  task automatic t_endpoints;
    int_en <= 1'b1;
    for (int n = 0; n < 4; n++) begin
      ep <= 4'(1 << n);
      cyc(1);
      ep <= 4'h0;
      cyc(1);
      check(32'(take), 32'(1'b1));
      rdchk(A_EP, 8'h40 | 8'((2 << n) - 1));
    end
    full <= 1'b1;
    cyc(1);
    check(32'(take), 32'(1'b0));
    full   <= 1'b0;
    int_en <= 1'b0;
    cyc(1);
    check(32'(take), 32'(1'b0));
    int_en <= 1'b1;
    wr8(A_EP, 8'h40);
    check(32'(take), 32'(1'b0));
    rdchk(A_EP, 8'h40);
  endtask

  task automatic t_wake;
    int w0;
    w0 = wk_cnt;
    wr8(A_SC, 8'hC2);
    rdchk(A_SC, 8'h30);
    cyc(60);
    wr8(A_SC, 8'hC0);
    check(wk_cnt - w0, 1);
    wr8(A_SC, 8'hC2);
    cyc(10);
    wr8(A_SC, 8'hC0);
    check(wk_cnt - w0, 1);
  endtask

  initial begin
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    t_reset();
    t_regs();
    t_pins();
    t_suspend();
    t_bus_reset();
    t_endpoints();
    t_wake();
    conclude();
  end
endmodule
`default_nettype wire
